// File: verilog/dtdt_map.vh
`ifndef DTDT_MAP_VH
`define DTDT_MAP_VH
// Clock period in ns, sized to the time output
`define DTDT_CLK_PERIOD_NS 24'h000005
// Instruction classes
`define DTDT_CLS_NONE 5'h00
`define DTDT_CLS_COPY_RS 5'h01
`define DTDT_CLS_COPY_RD 5'h02
`define DTDT_CLS_COPY_IMM_RM 5'h03
`define DTDT_CLS_COPY_IMM_R 5'h04
`define DTDT_CLS_ACC_LOAD 5'h05
`define DTDT_CLS_ACC_STORE 5'h06
`define DTDT_CLS_TO_SEG 5'h07
`define DTDT_CLS_FROM_SEG 5'h08
`define DTDT_CLS_SEXT 5'h09
`define DTDT_CLS_ZEXT 5'h0A
`define DTDT_CLS_PUSH_SEG 5'h0B
`define DTDT_CLS_POP_SEG 5'h0C
`define DTDT_CLS_SWAP_ACC 5'h0D
`define DTDT_CLS_SWAP_RM 5'h0E
`define DTDT_CLS_IN_FIX 5'h0F
`define DTDT_CLS_IN_VAR 5'h10
`define DTDT_CLS_OUT_FIX 5'h11
`define DTDT_CLS_OUT_VAR 5'h12
`define DTDT_CLS_ADDR_ONLY 5'h13
// Opcode bytes
`define DTDT_OP_ESCAPE 8'h0F
`define DTDT_OP_TO_SEG 8'h8E
`define DTDT_OP_FROM_SEG 8'h8C
`define DTDT_OP_ADDR_ONLY 8'h8D
// Base clock counts, register form and memory form
`define DTDT_CLK_2 6'h02
`define DTDT_CLK_3 6'h03
`define DTDT_CLK_4 6'h04
`define DTDT_CLK_5 6'h05
`define DTDT_CLK_6 6'h06
`define DTDT_CLK_7 6'h07
`define DTDT_CLK_22 6'h16
`define DTDT_CLK_23 6'h17
`define DTDT_CLK_25 6'h19
// Data cycle counts
`define DTDT_DC_0 4'h0
`define DTDT_DC_1 4'h1
`define DTDT_DC_2 4'h2
`define DTDT_DC_6 4'h6
// Penalties
`define DTDT_PEN_TWO_REG 6'h01
`define DTDT_PEN_EVEN_SINGLE 6'h02
`define DTDT_PEN_EVEN_RMW 6'h04
`define DTDT_PEN_ODD_SINGLE 6'h04
`define DTDT_PEN_ODD_RMW 6'h08
// Modrm mode meaning register operand
`define DTDT_MOD_REG 2'h3
`define DTDT_RM_SIB 3'h4
`endif

// File: verilog/dtdt_classify.v
`timescale 1ns/100ps
`include "dtdt_map.vh"
// Combinational opcode classifier
module dtdt_classify (
    input wire [7:0] op0, // First opcode byte
    input wire [7:0] op1, // Byte after the escape
    output reg [4:0] cls, // Instruction class
    output reg two_byte, // Escape form used
    output reg has_modrm, // Mode/reg/rm byte follows
    output reg [2:0] reg_fld, // Register or segment field
    output reg wide // Full-width operand
);

    ////////////////////////////////////////////////////////////
    // Opcode match; escape byte checked first
    always @*
    begin
        cls = `DTDT_CLS_NONE;
        two_byte = 1'b0;
        has_modrm = 1'b0;
        reg_fld = 3'h0;
        wide = op0[0];
        if (op0 == `DTDT_OP_ESCAPE)
        begin
            two_byte = 1'b1;
            wide = op1[0];
            if (op1[7:1] == 7'h5F)
            begin
                cls = `DTDT_CLS_SEXT;
                has_modrm = 1'b1;
            end
            else if (op1[7:1] == 7'h5B)
            begin
                cls = `DTDT_CLS_ZEXT;
                has_modrm = 1'b1;
            end
        end
        else if (op0[7:1] == 7'h44)
        begin
            cls = `DTDT_CLS_COPY_RS;
            has_modrm = 1'b1;
        end
        else if (op0[7:1] == 7'h45)
        begin
            cls = `DTDT_CLS_COPY_RD;
            has_modrm = 1'b1;
        end
        else if (op0[7:1] == 7'h63)
        begin
            cls = `DTDT_CLS_COPY_IMM_RM;
            has_modrm = 1'b1;
        end
        else if (op0[7:4] == 4'hB)
        begin
            cls = `DTDT_CLS_COPY_IMM_R;
            reg_fld = op0[2:0];
            wide = op0[3];
        end
        else if (op0[7:1] == 7'h50)
            cls = `DTDT_CLS_ACC_LOAD;
        else if (op0[7:1] == 7'h51)
            cls = `DTDT_CLS_ACC_STORE;
        else if (op0 == `DTDT_OP_TO_SEG)
        begin
            cls = `DTDT_CLS_TO_SEG;
            has_modrm = 1'b1;
            wide = 1'b1;
        end
        else if (op0 == `DTDT_OP_FROM_SEG)
        begin
            cls = `DTDT_CLS_FROM_SEG;
            has_modrm = 1'b1;
            wide = 1'b1;
        end
        else if (op0 == `DTDT_OP_ADDR_ONLY)
        begin
            cls = `DTDT_CLS_ADDR_ONLY;
            has_modrm = 1'b1;
            wide = 1'b1;
        end
        else if (op0[7:5] == 3'h0 && op0[2:0] == 3'h6)
        begin
            cls = `DTDT_CLS_PUSH_SEG;
            reg_fld = {1'b0, op0[4:3]};
            wide = 1'b1;
        end
        else if (op0[7:5] == 3'h0 && op0[2:0] == 3'h7 && op0[4:3] != 2'h1)
        begin
            // Code segment cannot be popped, so that slot stays undecoded
            cls = `DTDT_CLS_POP_SEG;
            reg_fld = {1'b0, op0[4:3]};
            wide = 1'b1;
        end
        else if (op0[7:3] == 5'h12)
        begin
            cls = `DTDT_CLS_SWAP_ACC;
            reg_fld = op0[2:0];
            wide = 1'b1;
        end
        else if (op0[7:1] == 7'h43)
        begin
            cls = `DTDT_CLS_SWAP_RM;
            has_modrm = 1'b1;
        end
        else if (op0[7:1] == 7'h72)
            cls = `DTDT_CLS_IN_FIX;
        else if (op0[7:1] == 7'h76)
            cls = `DTDT_CLS_IN_VAR;
        else if (op0[7:1] == 7'h73)
            cls = `DTDT_CLS_OUT_FIX;
        else if (op0[7:1] == 7'h77)
            cls = `DTDT_CLS_OUT_VAR;
    end

endmodule

// File: verilog/dtdt_decode.v
`timescale 1ns/100ps
`include "dtdt_map.vh"
// Behaviour
// - Time equals clock count times clock period
// - Two-register address adds one cycle
// - Misaligned16 or even 32-bit adds 2/4
// - Odd 32-bit operand adds 4/8
// - Each wait state adds one cycle when the instruction has a data cycle
// - Register count equal or lower, memory count equal or higher
// - Displacement, immediate each count one component
// - Register copy opcodes cost 2/2, 2/4
// - Short immediate-to-register copy takes 2 cycles
// - Accumulator load 4, store 2 cycles
// - Copy to segment 22/23, 0/6 data
// - Copy from segment takes 2 cycles
// - Sign-extend copy costs 3/6, fills sign
// - Zero-extend copy costs 3/6, clears upper
// - Segment stack store 4 cycles, 2 data
// - Segment stack load 25 cycles, 6 data
// - Accumulator swap 3 cycles, no data
// - Port read fixed or variable, one data
// - Port write fixed or variable, one data
// - Address-only load 2 cycles, no memory
module dtdt_decode (
    input wire clk, // Processor clock
    input wire sys_rst, // Asynchronous reset, active high
    input wire ins_valid, // Instruction bytes present
    input wire [7:0] ins_b0, // Opcode byte 0
    input wire [7:0] ins_b1, // Byte 1
    input wire [7:0] ins_b2, // Byte 2
    input wire [7:0] ins_b3, // Byte 3 (index byte in escape forms)
    input wire [1:0] misalign, // 0 aligned, 1 mis16 or even32, 2 odd32
    input wire [7:0] wait_states, // Wait states on this instruction's accesses
    input wire [31:0] ext_src, // Source value for extending copies
    output wire ins_ready, // Ready: low while the execution countdown runs
    output reg dec_valid_ff, // Decode result valid, one cycle
    output reg [4:0] dec_class_ff, // Instruction class
    output reg dec_wide_ff, // Full-width operand
    output reg [2:0] dec_reg_ff, // Register or segment field
    output reg dec_mem_ff, // Memory operand form
    output reg [3:0] dec_len_ff, // Component count
    output reg [3:0] dec_data_cyc_ff, // Data cycle count
    output reg [15:0] dec_clocks_ff, // Total clock count
    output reg [23:0] dec_time_ns_ff, // Execution time in ns
    output reg [31:0] ext_result_ff, // Extended copy result
    output reg busy_ff // Execution countdown running
);

    ////////////////////////////////////////////////////////////
    // Helpers

    // Clock count scaled to time
    function [23:0] to_ns;
        input [15:0] clocks;
        begin
            to_ns = {8'h00, clocks} * `DTDT_CLK_PERIOD_NS;
        end
    endfunction

    // Pick register or memory figure
    function [5:0] pick;
        input mem;
        input [5:0] reg_val;
        input [5:0] mem_val;
        begin
            pick = mem ? mem_val : reg_val;
        end
    endfunction

    ////////////////////////////////////////////////////////////
    // Classification
    wire [4:0] cls; // Class from classifier
    wire two_byte; // Escape form
    wire has_modrm; // Modrm follows opcode
    wire [2:0] reg_fld; // Register field from opcode
    wire wide; // Width bit

    dtdt_classify u_cls (
        .op0(ins_b0),
        .op1(ins_b1),
        .cls(cls),
        .two_byte(two_byte),
        .has_modrm(has_modrm),
        .reg_fld(reg_fld),
        .wide(wide)
    );

    ////////////////////////////////////////////////////////////
    // Modrm fields and address form
    wire [7:0] modrm = two_byte ? ins_b2 : ins_b1; // Mode/reg/rm byte
    wire [7:0] sib = two_byte ? ins_b3 : ins_b2; // Index byte
    wire [1:0] mod_f = modrm[7:6]; // Mode
    wire is_mem = has_modrm && (mod_f != `DTDT_MOD_REG); // Memory form
    wire has_sib = is_mem && (modrm[2:0] == `DTDT_RM_SIB); // Index byte used
    // Index plus base; mod 00 with base 101 has no base register
    wire two_reg = has_sib && (sib[5:3] != 3'h4) && !(mod_f == 2'h0 && sib[2:0] == 3'h5);
    // Base disp with mod 00, rm 101 is a full displacement
    wire disp_only = is_mem && (mod_f == 2'h0) && (modrm[2:0] == 3'h5);
    wire has_disp = is_mem && ((mod_f != 2'h0) || disp_only ||
        (has_sib && sib[2:0] == 3'h5 && mod_f == 2'h0));

    ////////////////////////////////////////////////////////////
    // Base clocks, data cycles, immediate presence
    reg [5:0] base_clk; // Base clock count
    reg [3:0] data_cyc; // Data cycle count
    reg has_imm; // Immediate unit present
    reg mem_acc; // Instruction touches memory
    reg rmw; // Read plus write access
    reg [2:0] out_reg; // Reported register field

    always @*
    begin
        base_clk = 6'h00;
        data_cyc = `DTDT_DC_0;
        has_imm = 1'b0;
        mem_acc = is_mem;
        rmw = 1'b0;
        out_reg = has_modrm ? modrm[5:3] : reg_fld;
        case (cls)
            `DTDT_CLS_COPY_RS:
            begin
                base_clk = pick(is_mem, `DTDT_CLK_2, `DTDT_CLK_2);
                data_cyc = is_mem ? `DTDT_DC_1 : `DTDT_DC_0;
            end
            `DTDT_CLS_COPY_RD:
            begin
                base_clk = pick(is_mem, `DTDT_CLK_2, `DTDT_CLK_4);
                data_cyc = is_mem ? `DTDT_DC_1 : `DTDT_DC_0;
            end
            `DTDT_CLS_COPY_IMM_RM:
            begin
                base_clk = pick(is_mem, `DTDT_CLK_2, `DTDT_CLK_2);
                data_cyc = is_mem ? `DTDT_DC_1 : `DTDT_DC_0;
                has_imm = 1'b1;
            end
            `DTDT_CLS_COPY_IMM_R:
            begin
                base_clk = `DTDT_CLK_2;
                has_imm = 1'b1;
            end
            `DTDT_CLS_ACC_LOAD:
            begin
                base_clk = `DTDT_CLK_4;
                data_cyc = `DTDT_DC_1;
                mem_acc = 1'b1;
            end
            `DTDT_CLS_ACC_STORE:
            begin
                base_clk = `DTDT_CLK_2;
                data_cyc = `DTDT_DC_1;
                mem_acc = 1'b1;
            end
            `DTDT_CLS_TO_SEG:
            begin
                base_clk = pick(is_mem, `DTDT_CLK_22, `DTDT_CLK_23);
                data_cyc = is_mem ? `DTDT_DC_6 : `DTDT_DC_0;
            end
            `DTDT_CLS_FROM_SEG:
            begin
                base_clk = `DTDT_CLK_2;
                data_cyc = is_mem ? `DTDT_DC_1 : `DTDT_DC_0;
            end
            `DTDT_CLS_SEXT, `DTDT_CLS_ZEXT:
            begin
                base_clk = pick(is_mem, `DTDT_CLK_3, `DTDT_CLK_6);
                data_cyc = is_mem ? `DTDT_DC_1 : `DTDT_DC_0;
            end
            `DTDT_CLS_PUSH_SEG:
            begin
                base_clk = `DTDT_CLK_4;
                data_cyc = `DTDT_DC_2;
                mem_acc = 1'b1;
            end
            `DTDT_CLS_POP_SEG:
            begin
                base_clk = `DTDT_CLK_25;
                data_cyc = `DTDT_DC_6;
                mem_acc = 1'b1;
            end
            `DTDT_CLS_SWAP_ACC:
            begin
                base_clk = `DTDT_CLK_3;
                mem_acc = 1'b0;
            end
            `DTDT_CLS_SWAP_RM:
            begin
                base_clk = pick(is_mem, `DTDT_CLK_3, `DTDT_CLK_5);
                data_cyc = is_mem ? `DTDT_DC_2 : `DTDT_DC_0;
                rmw = is_mem;
            end
            `DTDT_CLS_IN_FIX, `DTDT_CLS_IN_VAR:
            begin
                // Fixed form carries a port number byte, counted as immediate
                base_clk = (cls == `DTDT_CLS_IN_FIX) ? `DTDT_CLK_6 : `DTDT_CLK_7;
                data_cyc = `DTDT_DC_1;
                has_imm = (cls == `DTDT_CLS_IN_FIX);
                mem_acc = 1'b0;
            end
            `DTDT_CLS_OUT_FIX, `DTDT_CLS_OUT_VAR:
            begin
                base_clk = (cls == `DTDT_CLS_OUT_FIX) ? `DTDT_CLK_4 : `DTDT_CLK_5;
                data_cyc = `DTDT_DC_1;
                has_imm = (cls == `DTDT_CLS_OUT_FIX);
                mem_acc = 1'b0;
            end
            `DTDT_CLS_ADDR_ONLY:
            begin
                base_clk = `DTDT_CLK_2;
                mem_acc = 1'b0; // No memory access at all
            end
            default:
            begin
                base_clk = 6'h00;
                mem_acc = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////
    // Penalties and total
    reg [5:0] pen_align; // Misalignment penalty
    always @*
    begin
        pen_align = 6'h00;
        if (mem_acc)
        begin
            case (misalign)
                2'h1: pen_align = rmw ? `DTDT_PEN_EVEN_RMW : `DTDT_PEN_EVEN_SINGLE;
                2'h2: pen_align = rmw ? `DTDT_PEN_ODD_RMW : `DTDT_PEN_ODD_SINGLE;
                default: pen_align = 6'h00;
            endcase
        end
    end

    wire [5:0] pen_ea = (two_reg && cls != `DTDT_CLS_NONE) ? `DTDT_PEN_TWO_REG : 6'h00;
    // Waits only matter when a data access exists
    wire [7:0] waits = (data_cyc != `DTDT_DC_0) ? wait_states : 8'h00;
    wire [15:0] total = {10'h000, base_clk} + {10'h000, pen_ea} + {10'h000, pen_align}
        + {8'h00, waits};

    // Components: opcode bytes, modrm, index, one disp, one imm
    wire [3:0] comp = {3'h0, (cls != `DTDT_CLS_NONE)} + {3'h0, two_byte}
        + {3'h0, has_modrm} + {3'h0, has_sib} + {3'h0, has_disp | (cls == `DTDT_CLS_ACC_LOAD)
        | (cls == `DTDT_CLS_ACC_STORE)} + {3'h0, has_imm};

    // Extension result for the two extending copies
    reg [31:0] ext_val; // Extended value
    always @*
    begin
        if (cls == `DTDT_CLS_SEXT)
            ext_val = wide ? {{16{ext_src[15]}}, ext_src[15:0]}
                : {{24{ext_src[7]}}, ext_src[7:0]};
        else
            ext_val = wide ? {16'h0000, ext_src[15:0]} : {24'h000000, ext_src[7:0]};
    end

    ////////////////////////////////////////////////////////////
    // Result registers and execution countdown
    reg [15:0] cnt_ff; // Remaining execution clocks
    wire take = ins_valid && !busy_ff && (cls != `DTDT_CLS_NONE); // New instruction taken
    assign ins_ready = !busy_ff;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dec_valid_ff <= 1'b0;
            dec_class_ff <= `DTDT_CLS_NONE;
            dec_wide_ff <= 1'b0;
            dec_reg_ff <= 3'h0;
            dec_mem_ff <= 1'b0;
            dec_len_ff <= 4'h0;
            dec_data_cyc_ff <= 4'h0;
            dec_clocks_ff <= 16'h0000;
            dec_time_ns_ff <= 24'h000000;
            ext_result_ff <= 32'h00000000;
            busy_ff <= 1'b0;
            cnt_ff <= 16'h0000;
        end
        else
        begin
            dec_valid_ff <= take;
            if (take)
            begin
                dec_class_ff <= cls;
                dec_wide_ff <= wide;
                dec_reg_ff <= out_reg;
                dec_mem_ff <= mem_acc;
                dec_len_ff <= comp;
                dec_data_cyc_ff <= data_cyc;
                dec_clocks_ff <= total;
                dec_time_ns_ff <= to_ns(total);
                ext_result_ff <= ext_val;
                // Busy for total minus one clocks after the taking edge, ready again after the last one
                busy_ff <= (total > 16'h0001);
                cnt_ff <= total - 16'h0001;
            end
            else if (busy_ff)
            begin
                cnt_ff <= cnt_ff - 16'h0001;
                busy_ff <= (cnt_ff > 16'h0001);
            end
        end
    end

endmodule

// File: bench/dtdt_decode_asserts.sv
`timescale 1ns/100ps
`include "dtdt_map.vh"
////////////////////////////////////////////////////////////////
// Port-level checker for the decoder
module dtdt_decode_asserts (
    input wire clk, // Clock
    input wire sys_rst, // Reset
    input wire [1:0] misalign, // Alignment class
    input wire [7:0] wait_states, // Wait states
    input wire [31:0] ext_src, // Extension source
    input wire ins_ready, // Decoder can take
    input wire dec_valid_ff, // Result pulse
    input wire [4:0] dec_class_ff, // Class
    input wire dec_wide_ff, // Width
    input wire dec_mem_ff, // Memory form
    input wire [3:0] dec_data_cyc_ff, // Data cycles
    input wire [15:0] dec_clocks_ff, // Clock count
    input wire [23:0] dec_time_ns_ff, // Time in ns
    input wire [31:0] ext_result_ff, // Extended value
    input wire busy_ff // Countdown running
);
    reg [15:0] busy_cnt_ff; // Busy cycles so far
    wire [15:0] nxt_busy_cnt = busy_ff ? busy_cnt_ff + 16'h0001 : 16'h0000; // Count or clear
    // A counter instead of a long repetition keeps the tools fast
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_cnt_ff <= 16'h0000;
        end
        else
        begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    time_ns_a: assert property (dec_valid_ff |-> dec_time_ns_ff == {8'h00, dec_clocks_ff} * 24'h000005)
        else $error("time is not clocks times period");
    busy_len_a: assert property ($fell(busy_ff) |-> busy_cnt_ff == dec_clocks_ff - 16'h0001)
        else $error("busy stretch does not match clock count");
    refuse_busy_a: assert property (busy_ff |-> !ins_ready ##1 !dec_valid_ff)
        else $error("request taken while busy");
    reg_copy_a: assert property (dec_valid_ff && dec_class_ff == `DTDT_CLS_COPY_RD && !dec_mem_ff
        |-> dec_clocks_ff == 16'h0002 && dec_data_cyc_ff == 4'h0) else $error("register copy cost");
    pop_seg_a: assert property (dec_valid_ff && dec_class_ff == `DTDT_CLS_POP_SEG
        && $past(misalign) == 2'h0 |-> dec_clocks_ff == 16'h0019 + {8'h00, $past(wait_states)}
        && dec_data_cyc_ff == 4'h6) else $error("segment stack load cost");
    swap_acc_a: assert property (dec_valid_ff && dec_class_ff == `DTDT_CLS_SWAP_ACC
        |-> dec_clocks_ff == 16'h0003 && dec_data_cyc_ff == 4'h0) else $error("swap cost");
    port_data_a: assert property (dec_valid_ff && dec_class_ff >= `DTDT_CLS_IN_FIX
        && dec_class_ff <= `DTDT_CLS_OUT_VAR |-> dec_data_cyc_ff == 4'h1) else $error("port data");
    sign_fill_a: assert property (dec_valid_ff && dec_class_ff == `DTDT_CLS_SEXT && !dec_wide_ff
        |-> ext_result_ff == {{24{$past(ext_src[7])}}, $past(ext_src[7:0])})
        else $error("sign fill wrong");
    zero_fill_a: assert property (dec_valid_ff && dec_class_ff == `DTDT_CLS_ZEXT && !dec_wide_ff
        |-> ext_result_ff == {24'h000000, $past(ext_src[7:0])}) else $error("zero fill wrong");
endmodule
bind dtdt_decode dtdt_decode_asserts u_chk (.*);

// File: bench/dtdt_pipe_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Pipeline side: offers one instruction at a time
module dtdt_pipe_model (
    input wire clk, // Clock
    input wire ins_ready, // Decoder can take
    output reg ins_valid, // Offer present
    output reg [7:0] ins_b0, // Byte 0
    output reg [7:0] ins_b1, // Byte 1
    output reg [7:0] ins_b2, // Byte 2
    output reg [7:0] ins_b3, // Byte 3
    output reg [1:0] misalign, // Operand alignment
    output reg [7:0] wait_states, // Wait states from memory
    output reg [31:0] ext_src // Source for extension
);
    // Idle values at time zero
    initial
    begin
        ins_valid = 1'b0;
        {ins_b0, ins_b1, ins_b2, ins_b3} = 32'h00000000;
        misalign = 2'h0;
        wait_states = 8'h00;
        ext_src = 32'h00000000;
    end
    // Hold the offer until an edge sees ready, then drop it
    task send(input [31:0] bytes, input [1:0] mis, input [7:0] ws, input [31:0] src,
        output ok);
        integer n;
        begin
            n = 0;
            @(negedge clk);
            {ins_b0, ins_b1, ins_b2, ins_b3} = bytes;
            misalign = mis;
            wait_states = ws;
            ext_src = src;
            ins_valid = 1'b1;
            // Ready moves only on rising edges, so it is settled here
            while (!ins_ready && n < 100)
            begin
                @(negedge clk);
                n = n + 1;
            end
            ok = ins_ready;
            @(negedge clk);
            ins_valid = 1'b0;
            // Released bytes, source and waits show garbage, not the last value
            {ins_b0, ins_b1, ins_b2, ins_b3} = ~bytes;
            ext_src = ~src;
            wait_states = ~ws;
        end
    endtask
    // Offer for a fixed count of cycles whatever ready says
    task offer(input [31:0] bytes, input integer cyc);
        begin
            @(negedge clk);
            {ins_b0, ins_b1, ins_b2, ins_b3} = bytes;
            ins_valid = 1'b1;
            repeat (cyc) @(negedge clk);
            ins_valid = 1'b0;
        end
    endtask
endmodule

// File: bench/data_transfer_decode_timing_tb.sv
`timescale 1ns/100ps
`include "dtdt_map.vh"
////////////////////////////////////////////////////////////////
// Self-checking bench for the transfer decoder
module data_transfer_decode_timing_tb;
    reg clk = 1'b0; // 200 MHz clock
    reg sys_rst = 1'b1; // Reset, held at start
    integer error_cnt = 0; // Mismatches
    integer check_count = 0; // Comparisons
    integer cyc_cnt = 0; // Cycles run
    wire ins_valid, ins_ready, dec_valid_ff, dec_wide_ff, dec_mem_ff, busy_ff;
    wire [7:0] ins_b0, ins_b1, ins_b2, ins_b3, wait_states;
    wire [1:0] misalign;
    wire [31:0] ext_src, ext_result_ff;
    wire [4:0] dec_class_ff;
    wire [2:0] dec_reg_ff;
    wire [3:0] dec_len_ff, dec_data_cyc_ff;
    wire [15:0] dec_clocks_ff;
    wire [23:0] dec_time_ns_ff;
    always #2.5 clk = ~clk;
    dtdt_decode u_dut (.*);
    dtdt_pipe_model u_pipe (.*);
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    // One instruction: class, cost, time; dc 4'hF skips data cycles
    task op(input [31:0] bytes, input [1:0] mis, input [7:0] ws, input [31:0] src,
        input [4:0] cls, input [15:0] clks, input [3:0] dc);
        reg ok;
        begin
            u_pipe.send(bytes, mis, ws, src, ok);
            check(ok, 1'b1);
            check(dec_valid_ff, 1'b1);
            check(dec_class_ff, cls);
            check(dec_clocks_ff, clks);
            check(dec_time_ns_ff, clks * 5);
            if (dc != 4'hF)
                check(dec_data_cyc_ff, dc);
        end
    endtask
    // Register and memory copies, width and register fields
    task t_copy;
        begin
            op(32'h8BC00000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_RD, 2, 0);
            check(dec_mem_ff, 0);
            check(dec_wide_ff, 1);
            check(dec_len_ff, 2);
            op(32'h8AC80000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_RD, 2, 0);
            check(dec_wide_ff, 0);
            check(dec_reg_ff, 1);
            op(32'h89C00000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_RS, 2, 0);
            op(32'h89000000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_RS, 2, 1);
            check(dec_mem_ff, 1);
            op(32'h8B000000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_RD, 4, 1);
        end
    endtask
    // Alignment penalties for single and read-write accesses, plus wait states
    task t_penalty;
        begin
            op(32'h8B000000, 2'h1, 8'h00, 0, `DTDT_CLS_COPY_RD, 6, 1);
            op(32'h8B000000, 2'h2, 8'h00, 0, `DTDT_CLS_COPY_RD, 8, 1);
            op(32'h8B000000, 2'h2, 8'h03, 0, `DTDT_CLS_COPY_RD, 11, 1);
            op(32'h87000000, 2'h1, 8'h00, 0, `DTDT_CLS_SWAP_RM, 9, 2);
            op(32'h87000000, 2'h2, 8'h00, 0, `DTDT_CLS_SWAP_RM, 13, 2);
            op(32'h0FB60408, 2'h0, 8'h00, 0, `DTDT_CLS_ZEXT, 7, 1);
            op(32'h0FB60420, 2'h0, 8'h00, 0, `DTDT_CLS_ZEXT, 6, 1);
            op(32'h0FB6040D, 2'h0, 8'h00, 0, `DTDT_CLS_ZEXT, 6, 1);
        end
    endtask
    // Extending copies fill or clear the upper bits
    task t_extend;
        begin
            op(32'h0FBEC000, 2'h0, 8'h00, 32'h00000080, `DTDT_CLS_SEXT, 3, 0);
            check(ext_result_ff, 32'hFFFFFF80);
            check(dec_len_ff, 3);
            op(32'h0FB6C000, 2'h0, 8'h00, 32'h123456F0, `DTDT_CLS_ZEXT, 3, 0);
            check(ext_result_ff, 32'h000000F0);
            op(32'h0FBFC000, 2'h0, 8'h00, 32'h00008001, `DTDT_CLS_SEXT, 3, 0);
            check(ext_result_ff, 32'hFFFF8001);
            op(32'h0FB7C000, 2'h0, 8'h00, 32'hFFFF8001, `DTDT_CLS_ZEXT, 3, 0);
            check(ext_result_ff, 32'h00008001);
        end
    endtask
    // Segment copies and segment stack store and load
    task t_segment;
        begin
            op(32'h8ED80000, 2'h0, 8'h00, 0, `DTDT_CLS_TO_SEG, 22, 0);
            check(dec_reg_ff, 3);
            op(32'h8E180000, 2'h0, 8'h00, 0, `DTDT_CLS_TO_SEG, 23, 6);
            op(32'h8CD80000, 2'h0, 8'h00, 0, `DTDT_CLS_FROM_SEG, 2, 0);
            op(32'h06000000, 2'h0, 8'h00, 0, `DTDT_CLS_PUSH_SEG, 4, 2);
            check(dec_reg_ff, 0);
            op(32'h1E000000, 2'h0, 8'h00, 0, `DTDT_CLS_PUSH_SEG, 4, 2);
            check(dec_reg_ff, 3);
            op(32'h17000000, 2'h0, 8'h02, 0, `DTDT_CLS_POP_SEG, 27, 6);
            check(dec_reg_ff, 2);
        end
    endtask
    // Short forms, swap and address-only load; wait states need a data access
    task t_short;
        begin
            op(32'hB8000000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_IMM_R, 2, 4'hF);
            check(dec_len_ff, 2);
            op(32'hB1000000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_IMM_R, 2, 4'hF);
            check(dec_wide_ff, 0);
            check(dec_reg_ff, 1);
            op(32'hA1000000, 2'h0, 8'h00, 0, `DTDT_CLS_ACC_LOAD, 4, 1);
            op(32'hA3000000, 2'h0, 8'h00, 0, `DTDT_CLS_ACC_STORE, 2, 1);
            op(32'h91000000, 2'h0, 8'h05, 0, `DTDT_CLS_SWAP_ACC, 3, 0);
            check(dec_reg_ff, 1);
            op(32'h8D000000, 2'h0, 8'h05, 0, `DTDT_CLS_ADDR_ONLY, 2, 0);
            check(dec_mem_ff, 0);
        end
    endtask
    // Port transfers: one data cycle, no alignment penalty
    task t_ports;
        begin
            op(32'hE4000000, 2'h2, 8'h02, 0, `DTDT_CLS_IN_FIX, 8, 1);
            check(dec_len_ff, 2);
            op(32'hEC000000, 2'h2, 8'h02, 0, `DTDT_CLS_IN_VAR, 9, 1);
            op(32'hE6000000, 2'h2, 8'h02, 0, `DTDT_CLS_OUT_FIX, 6, 1);
            op(32'hEE000000, 2'h2, 8'h02, 0, `DTDT_CLS_OUT_VAR, 7, 1);
        end
    endtask
    // An offer during a long operation is refused, then taken afterwards
    task t_refuse;
        begin
            op(32'h1F000000, 2'h0, 8'h00, 0, `DTDT_CLS_POP_SEG, 25, 6);
            u_pipe.offer(32'h8BC00000, 10);
            check(ins_ready, 0);
            check(busy_ff, 1);
            check(dec_class_ff, `DTDT_CLS_POP_SEG);
            op(32'h8BC00000, 2'h0, 8'h00, 0, `DTDT_CLS_COPY_RD, 2, 0);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task complete_run;
        begin
            $display("checks %0d, errors %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Cuts a hang short; the whole run needs far fewer cycles
    always @(posedge clk)
    begin
        cyc_cnt = cyc_cnt + 1;
        if (cyc_cnt == 5000)
        begin
            error_cnt = error_cnt + 1;
            complete_run;
        end
    end
    // Main sequence
    initial
    begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        t_copy;
        t_penalty;
        t_extend;
        t_segment;
        t_short;
        t_ports;
        t_refuse;
        complete_run;
    end
endmodule
